//--- logic/qa_watchdog_reset.v
// query/answer watchdog: response check, error tally and monitor reset
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "qa_watchdog_map.vh"

// What this block does
// - enable clear: monitor reset request stays inactive; error tally drops on good answers and on overflow
// - enable clear: reset tally unchanged on error tally overflow
// - enable set, overflow in a run, reset tally 0..6: request a reset
// - reset tally at 7 and overflow: no reset request
// - reset tally counts up per qualifying overflow, saturates at 7
// - reset tally never counts down; only undervoltage reset zeroes it
// - monitor reset sets occurred flag; reading it clears it
// - reset tally readable, not writable
// - test mode forces alarm pin active; internal alarm unaffected
// - undervoltage reset: internal alarm one, shutdown and request zero
// - 2-bit byte counter selects expected byte, default 11
// - mismatch flag set on any wrong byte, default zero, feeds tally
// - each sequencer run restores byte counter and mismatch flag
// - each byte write updates flag, steps counter 11,10,01,00
// - byte write at counter 00 launches sequencer, counter back to 11
// - expected byte is a fixed XOR of question bits and counter
// - undervoltage clears all; partial reset restores tally, delay, timer
// - partial reset active while reset pin or soft reset active
// - overflow when error tally is seven and another error occurs
// - run starts on last byte, delay write, or window end
module qa_watchdog_reset
#(
  parameter RESET_PULSE_NS = `QAW_RESET_PULSE_NS
)
(
  input  wire       REF_CLK_IN,        // 20 MHz clock
  input  wire       RESETN_IN,         // undervoltage reset, active low
  input  wire [7:0] ADDR_IN,           // register address
  input  wire [7:0] WDATA_IN,          // register write data
  input  wire       WR_IN,             // write strobe
  input  wire       RD_IN,             // read strobe
  output reg  [7:0] RDATA_OUT,         // read data, cycle after strobe
  input  wire [3:0] QUESTION_IN,       // current question bits
  input  wire       IN_WINDOW_IN,      // fixed time window open
  input  wire       WINDOW_END_IN,     // fixed window ended, pulse
  input  wire       BASE_TICK_IN,      // base time tick, pulse
  input  wire       EXT_RESET_N_IN,    // other reset sources, pin
  input  wire       ALARM_PIN_IN,      // alarm pin level, pin
  output wire       ALARM_PIN_OUT,     // alarm pin drive level
  output wire       ALARM_PIN_OE_OUT,  // alarm pin drive enable
  output wire       RESET_PIN_N_OUT,   // reset pin, active low
  output reg        INTERNAL_ALARM_OUT,// internal alarm level
  output reg        SHUTDOWN_OUT,      // afterrun shutdown
  output reg        MON_RESET_OUT,     // monitor reset request
  output wire       PARTIAL_RESET_OUT  // partial reset level
);

  localparam integer PULSE_RAW =
    RESET_PULSE_NS / `QAW_CLK_PERIOD_NS;
  localparam integer PULSE_CYCLES = (PULSE_RAW < 1) ? 1 : PULSE_RAW;

  localparam CAUSE_RESPONSE = 2'd0;
  localparam CAUSE_DELAY    = 2'd1;
  localparam CAUSE_WINDOW   = 2'd2;

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  // pin synchronisers
  reg        ext_rst_meta;
  reg        ext_rst_n;
  reg        alarm_meta;
  reg        alarm_pin;

  // control
  reg        reset_generation_enable;
  reg        test_mode;
  reg        soft_reset_request;
  reg  [7:0] response_delay_setting;

  // sequencer and comparison
  reg        state;
  reg  [1:0] run_cause;
  reg        run_in_window;
  reg  [1:0] byte_count;
  reg        mismatch;
  reg  [2:0] error_tally;
  reg        overflow;
  reg  [2:0] reset_tally;
  reg        occurred_flag;
  reg  [2:0] afterrun_tally;
  reg  [4:0] timer_state;
  reg [15:0] pulse_count;

  wire [7:0] expected_byte;
  wire       byte_wrong;
  wire       write_response;
  wire       write_delay;
  wire       sequencer_launch;
  wire       run_start;
  wire       run_error;
  wire       run_overflow;
  wire       partial_reset;
  wire       reset_pin_active;
  wire       read_status;

  resp_byte_check u_check
  (
    .question_in  (QUESTION_IN),
    .count_in     (byte_count),
    .byte_in      (WDATA_IN),
    .expected_out (expected_byte),
    .mismatch_out (byte_wrong)
  );

  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      ext_rst_meta <= 1'b1;
      ext_rst_n    <= 1'b1;
      alarm_meta   <= 1'b1;
      alarm_pin    <= 1'b1;
    end
    else
    begin
      ext_rst_meta <= EXT_RESET_N_IN;
      ext_rst_n    <= ext_rst_meta;
      alarm_meta   <= ALARM_PIN_IN;
      alarm_pin    <= alarm_meta;
    end
  end

  // response and delay writes are refused while a run is in progress
  assign write_response = WR_IN && (ADDR_IN == `QAW_ADDR_RESPONSE)
                          && (state == ST_IDLE);
  assign write_delay    = WR_IN && (ADDR_IN == `QAW_ADDR_DELAY)
                          && (state == ST_IDLE);
  assign sequencer_launch = write_response && (byte_count == 2'b00);
  assign run_start = sequencer_launch || write_delay
                     || (WINDOW_END_IN && (state == ST_IDLE));
  assign read_status = RD_IN && (ADDR_IN == `QAW_ADDR_STATUS);

  // a zero delay or a delay/window run always counts as an error
  assign run_error = (run_cause != CAUSE_RESPONSE) || mismatch
                     || !run_in_window
                     || (response_delay_setting == 8'h00);
  assign run_overflow = (state == ST_RUN) && run_error
                        && (error_tally == `QAW_ERROR_MAX);

  assign reset_pin_active = (pulse_count != 16'h0000) || !ext_rst_n;
  assign partial_reset = reset_pin_active || soft_reset_request;
  assign PARTIAL_RESET_OUT = partial_reset;
  assign RESET_PIN_N_OUT   = !reset_pin_active;

  // open-drain alarm: only ever pulls low
  assign ALARM_PIN_OUT    = 1'b0;
  assign ALARM_PIN_OE_OUT = INTERNAL_ALARM_OUT || test_mode;

  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      reset_generation_enable <= 1'b0;
      test_mode               <= 1'b0;
      soft_reset_request      <= 1'b0;
    end
    else
    begin
      soft_reset_request <= 1'b0;
      if (WR_IN && (ADDR_IN == `QAW_ADDR_CONTROL))
      begin
        reset_generation_enable <= WDATA_IN[`QAW_CTRL_RESET_GEN_BIT];
        test_mode               <= WDATA_IN[`QAW_CTRL_TEST_MODE_BIT];
        soft_reset_request      <= WDATA_IN[`QAW_CTRL_SOFT_RST_BIT];
      end
    end
  end

  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
      response_delay_setting <= `QAW_DELAY_RESET;
    else if (partial_reset)
      response_delay_setting <= `QAW_DELAY_RESET;
    else if (write_delay)
      response_delay_setting <= WDATA_IN;
  end

  // sequencer: one idle state, one run cycle
  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      state         <= ST_IDLE;
      run_cause     <= CAUSE_RESPONSE;
      run_in_window <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (run_start)
          begin
            state         <= ST_RUN;
            run_in_window <= IN_WINDOW_IN;
            if (sequencer_launch)
              run_cause <= CAUSE_RESPONSE;
            else if (write_delay)
              run_cause <= CAUSE_DELAY;
            else
              run_cause <= CAUSE_WINDOW;
          end
        end
        ST_RUN:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // byte counter and mismatch flag
  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      byte_count <= `QAW_COUNT_RESET;
      mismatch   <= 1'b0;
    end
    else if (state == ST_RUN)
    begin
      byte_count <= `QAW_COUNT_RESET;
      mismatch   <= 1'b0;
    end
    else if (write_response)
    begin
      byte_count <= byte_count - 2'b01;
      mismatch   <= mismatch | byte_wrong;
    end
  end

  // error tally and overflow register
  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      error_tally <= `QAW_ERROR_RESET;
      overflow    <= 1'b0;
    end
    else if (partial_reset)
    begin
      error_tally <= `QAW_ERROR_RESET;
      overflow    <= 1'b0;
    end
    else if (state == ST_RUN)
    begin
      overflow <= run_overflow;
      if (run_overflow)
        error_tally <= `QAW_ERROR_RESET;
      else if (run_error)
        error_tally <= error_tally + 3'h1;
      else if (error_tally != 3'h0)
        error_tally <= error_tally - 3'h1;
    end
  end

  // reset tally, monitor reset request, occurred flag
  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      reset_tally   <= 3'h0;
      MON_RESET_OUT <= 1'b0;
      occurred_flag <= 1'b0;
    end
    else
    begin
      MON_RESET_OUT <= 1'b0;
      if (run_overflow && reset_generation_enable)
      begin
        if (reset_tally != `QAW_TALLY_MAX)
        begin
          reset_tally   <= reset_tally + 3'h1;
          MON_RESET_OUT <= 1'b1;
        end
        else
          MON_RESET_OUT <= 1'b0;
      end
      // a new reset in the read cycle wins over the clear
      if (MON_RESET_OUT)
        occurred_flag <= 1'b1;
      else if (read_status)
        occurred_flag <= 1'b0;
    end
  end

  // stretches the one-cycle request into a reset pin pulse
  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
      pulse_count <= 16'h0000;
    else if (MON_RESET_OUT)
      pulse_count <= PULSE_CYCLES[15:0];
    else if (pulse_count != 16'h0000)
      pulse_count <= pulse_count - 16'h0001;
  end

  // internal alarm follows the tally only, never the test mode
  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
      INTERNAL_ALARM_OUT <= 1'b1;
    else
      INTERNAL_ALARM_OUT <= (error_tally >= `QAW_ERROR_ALARM_MIN);
  end

  // afterrun tally and shutdown
  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
    begin
      afterrun_tally <= 3'h0;
      SHUTDOWN_OUT   <= 1'b0;
    end
    else if (!INTERNAL_ALARM_OUT)
    begin
      afterrun_tally <= 3'h0;
      SHUTDOWN_OUT   <= 1'b0;
    end
    else if (run_overflow || soft_reset_request)
    begin
      if (afterrun_tally != `QAW_AFTERRUN_MAX)
        afterrun_tally <= afterrun_tally + 3'h1;
      else
        SHUTDOWN_OUT <= 1'b1;
    end
  end

  // timer state: base ticks since the last run, saturating
  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
      timer_state <= `QAW_TIMER_RESET;
    else if (partial_reset || (state == ST_RUN))
      timer_state <= `QAW_TIMER_RESET;
    else if (BASE_TICK_IN && (timer_state != `QAW_TIMER_MAX))
      timer_state <= timer_state + 5'h01;
  end

  // read port; no register accepts a write to the reset tally
  always @(posedge REF_CLK_IN)
  begin
    if (!RESETN_IN)
      RDATA_OUT <= 8'h00;
    else if (RD_IN)
    begin
      case (ADDR_IN)
        `QAW_ADDR_DELAY:
          RDATA_OUT <= response_delay_setting;
        `QAW_ADDR_CONTROL:
        begin
          RDATA_OUT <= 8'h00;
          RDATA_OUT[`QAW_CTRL_RESET_GEN_BIT] <= reset_generation_enable;
          RDATA_OUT[`QAW_CTRL_TEST_MODE_BIT] <= test_mode;
        end
        `QAW_ADDR_STATUS:
        begin
          RDATA_OUT[`QAW_STAT_OCCURRED_BIT] <= occurred_flag;
          RDATA_OUT[`QAW_STAT_TALLY_LSB +: 3] <= reset_tally;
          RDATA_OUT[`QAW_STAT_ERROR_LSB +: 3] <= error_tally;
          RDATA_OUT[`QAW_STAT_ALARM_BIT] <= INTERNAL_ALARM_OUT;
        end
        `QAW_ADDR_COMPARE:
        begin
          RDATA_OUT[`QAW_CMP_COUNT_LSB +: 2] <= byte_count;
          RDATA_OUT[`QAW_CMP_MISMATCH_BIT] <= mismatch;
          RDATA_OUT[`QAW_CMP_OVERFLOW_BIT] <= overflow;
          RDATA_OUT[`QAW_CMP_QUESTION_LSB +: 4] <= QUESTION_IN;
        end
        `QAW_ADDR_TIMER:
        begin
          RDATA_OUT[`QAW_TMR_STATE_LSB +: 5] <= timer_state;
          RDATA_OUT[`QAW_TMR_SHUTDOWN_BIT] <= SHUTDOWN_OUT;
          RDATA_OUT[`QAW_TMR_PIN_SEEN_BIT] <= !alarm_pin;
          RDATA_OUT[`QAW_TMR_RST_PIN_BIT] <= reset_pin_active;
        end
        default:
          RDATA_OUT <= 8'h00;
      endcase
    end
    else
      RDATA_OUT <= 8'h00;
  end

endmodule // qa_watchdog_reset

//--- logic/qa_watchdog_map.vh
// constants for the query/answer watchdog reset and comparison logic
`ifndef QA_WATCHDOG_MAP_VH
`define QA_WATCHDOG_MAP_VH

// register offsets
`define QAW_ADDR_RESPONSE      8'h00
`define QAW_ADDR_DELAY         8'h01
`define QAW_ADDR_CONTROL       8'h02
`define QAW_ADDR_STATUS        8'h03
`define QAW_ADDR_COMPARE       8'h04
`define QAW_ADDR_TIMER         8'h05

// control register fields
`define QAW_CTRL_RESET_GEN_BIT 0
`define QAW_CTRL_SOFT_RST_BIT  1
`define QAW_CTRL_TEST_MODE_BIT 2

// status register fields
`define QAW_STAT_OCCURRED_BIT  0
`define QAW_STAT_TALLY_LSB     1
`define QAW_STAT_ERROR_LSB     4
`define QAW_STAT_ALARM_BIT     7

// compare register fields
`define QAW_CMP_COUNT_LSB      0
`define QAW_CMP_MISMATCH_BIT   2
`define QAW_CMP_OVERFLOW_BIT   3
`define QAW_CMP_QUESTION_LSB   4

// timer register fields
`define QAW_TMR_STATE_LSB      0
`define QAW_TMR_SHUTDOWN_BIT   5
`define QAW_TMR_PIN_SEEN_BIT   6
`define QAW_TMR_RST_PIN_BIT    7

// reset values and limits
`define QAW_ERROR_RESET        3'h6
`define QAW_ERROR_MAX          3'h7
`define QAW_ERROR_ALARM_MIN    3'h5
`define QAW_DELAY_RESET        8'h3F
`define QAW_COUNT_RESET        2'h3
`define QAW_TALLY_MAX          3'h7
`define QAW_AFTERRUN_MAX       3'h7
`define QAW_TIMER_RESET        5'h00
`define QAW_TIMER_MAX          5'h1F

// timing
`define QAW_CLK_PERIOD_NS      50
`define QAW_RESET_PULSE_NS     10000

`endif

//--- logic/resp_byte_check.v
// expected response byte generator and byte comparator
`timescale 1ns/1ps

module resp_byte_check
(
  input  wire [3:0] question_in,   // current question bits
  input  wire [1:0] count_in,      // response byte counter
  input  wire [7:0] byte_in,       // response byte written by software
  output wire [7:0] expected_out,  // expected response byte
  output wire       mismatch_out   // byte differs from expectation
);

  wire q0;
  wire q1;
  wire q2;
  wire q3;

  assign q0 = question_in[0];
  assign q1 = question_in[1];
  assign q2 = question_in[2];
  assign q3 = question_in[3];

  assign expected_out[7] = q2 ^ count_in[0];
  assign expected_out[6] = q0 ^ count_in[0];
  assign expected_out[5] = q3 ^ count_in[0];
  assign expected_out[4] = q1 ^ count_in[0];
  assign expected_out[3] = q2 ^ q0 ^ q3 ^ count_in[1];
  assign expected_out[2] = q0 ^ q3 ^ q1 ^ count_in[1];
  assign expected_out[1] = q2 ^ q0 ^ q1 ^ count_in[1];
  assign expected_out[0] = count_in[1] ^ q3 ^ q0;

  assign mismatch_out = (expected_out != byte_in);

endmodule // resp_byte_check

//--- test/mcu_responder.sv
// behavioural microcontroller that works out each response byte
`timescale 1ns/1ps
module mcu_responder
(
  input  wire [3:0] question_in, // question fetched from the watchdog
  input  wire [1:0] count_in,    // byte position, 3 = most significant
  input  wire       spoil_in,    // corrupt this byte on purpose
  output wire [7:0] byte_out     // response byte to write
);
  wire [3:0] q = question_in;
  wire [1:0] c = count_in;
  // a spoiled byte flips bit 0 only, the smallest slip to catch
  assign byte_out = {q[2] ^ c[0], q[0] ^ c[0], q[3] ^ c[0], q[1] ^ c[0],
                     q[2] ^ q[0] ^ q[3] ^ c[1], q[0] ^ q[3] ^ q[1] ^ c[1],
                     q[2] ^ q[0] ^ q[1] ^ c[1],
                     c[1] ^ q[3] ^ q[0] ^ spoil_in};
endmodule // mcu_responder

//--- test/qa_watchdog_reset_chk.sv
// assertions on the ports of the watchdog reset logic
`timescale 1ns/1ps
module qa_watchdog_reset_chk
#(
  parameter RESET_PULSE_NS = 10000
)
(
  input wire       REF_CLK_IN,
  input wire       RESETN_IN,
  input wire [7:0] ADDR_IN,
  input wire [7:0] WDATA_IN,
  input wire       WR_IN,
  input wire       RD_IN,
  input wire [7:0] RDATA_OUT,
  input wire [3:0] QUESTION_IN,
  input wire       IN_WINDOW_IN,
  input wire       WINDOW_END_IN,
  input wire       BASE_TICK_IN,
  input wire       EXT_RESET_N_IN,
  input wire       ALARM_PIN_IN,
  input wire       ALARM_PIN_OUT,
  input wire       ALARM_PIN_OE_OUT,
  input wire       RESET_PIN_N_OUT,
  input wire       INTERNAL_ALARM_OUT,
  input wire       SHUTDOWN_OUT,
  input wire       MON_RESET_OUT,
  input wire       PARTIAL_RESET_OUT
);
  localparam int PULSE_CYC = RESET_PULSE_NS / 50;
  reg       en = 1'b0;
  reg       test = 1'b0;
  reg [2:0] monc = 3'h0;
  int       lowc = 1000;
  // shadow of the control bits and of the monitor resets seen so far
  always @(posedge REF_CLK_IN)
    if (!RESETN_IN)
    begin
      en <= 1'b0;
      test <= 1'b0;
      monc <= 3'h0;
      lowc <= 1000;
    end
    else
    begin
      if (WR_IN && ADDR_IN == 8'h02)
      begin
        en <= WDATA_IN[0];
        test <= WDATA_IN[2];
      end
      if (MON_RESET_OUT && monc != 3'h7)
        monc <= monc + 3'h1;
      if (MON_RESET_OUT)
        lowc <= 0;
      else if (lowc < 1000)
        lowc <= lowc + 1;
    end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  property p_mon_en; MON_RESET_OUT |-> en; endproperty
  a_mon_en: assert property (p_mon_en)
    else $error("monitor reset while disabled");
  property p_mon_cap; MON_RESET_OUT |-> monc != 3'h7; endproperty
  a_mon_cap: assert property (p_mon_cap)
    else $error("eighth monitor reset");
  property p_mon_pin;
    MON_RESET_OUT |=> !MON_RESET_OUT && !RESET_PIN_N_OUT;
  endproperty
  a_mon_pin: assert property (p_mon_pin)
    else $error("monitor reset not on reset pin");
  property p_pulse;
    lowc < PULSE_CYC |-> !RESET_PIN_N_OUT && PARTIAL_RESET_OUT;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse too short");
  property p_prl_ext;
    (!EXT_RESET_N_IN) [*3] |-> PARTIAL_RESET_OUT;
  endproperty
  a_prl_ext: assert property (p_prl_ext)
    else $error("no partial reset from reset pin");
  property p_uv;
    disable iff (1'b0)
    !RESETN_IN |=> INTERNAL_ALARM_OUT && !SHUTDOWN_OUT && !MON_RESET_OUT;
  endproperty
  a_uv: assert property (p_uv)
    else $error("wrong state under undervoltage reset");
  property p_test; test |-> ALARM_PIN_OE_OUT && !ALARM_PIN_OUT; endproperty
  a_test: assert property (p_test)
    else $error("alarm pin idle in test mode");
  property p_alarm; INTERNAL_ALARM_OUT |-> ALARM_PIN_OE_OUT; endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm pin idle while alarm set");
  property p_tally;
    RD_IN && ADDR_IN == 8'h03 |=> RDATA_OUT[3:1] == monc;
  endproperty
  a_tally: assert property (p_tally)
    else $error("reset tally differs from resets seen");
endmodule // qa_watchdog_reset_chk

bind qa_watchdog_reset qa_watchdog_reset_chk
  #(.RESET_PULSE_NS(RESET_PULSE_NS)) u_chk (.REF_CLK_IN, .RESETN_IN,
  .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .QUESTION_IN,
  .IN_WINDOW_IN, .WINDOW_END_IN, .BASE_TICK_IN, .EXT_RESET_N_IN,
  .ALARM_PIN_IN, .ALARM_PIN_OUT, .ALARM_PIN_OE_OUT, .RESET_PIN_N_OUT,
  .INTERNAL_ALARM_OUT, .SHUTDOWN_OUT, .MON_RESET_OUT, .PARTIAL_RESET_OUT);

//--- test/tb_qa_watchdog_reset.sv
// self-checking bench for the watchdog reset and comparison logic
`timescale 1ns/1ps
module tb_qa_watchdog_reset;
  reg        clk = 0;
  reg        rst_n = 0;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 0;
  reg        rd = 0;
  reg  [3:0] question = 4'h0;
  reg        in_win = 1;
  reg        win_end = 0;
  reg        tick = 0;
  reg        ext_n = 1;
  reg  [1:0] cnt = 2'h3;
  reg        spoil = 0;
  reg  [2:0] err = 3'h6;
  reg  [2:0] rt = 3'h0;
  reg  [7:0] d;
  reg  [3:0] qr;
  integer    errors = 0;
  integer    comparisons = 0;
  integer    mon_seen = 0;
  integer    i;
  wire [7:0] rdata;
  wire [7:0] answer_byte;
  wire       a_out, a_oe, rpin_n, ialarm, shut, mon, partial;
  wire       alarm_pin = a_oe ? a_out : 1'b1; // pulled up when released

  always #25 clk = ~clk;
  always @(posedge clk)
    if (mon === 1'b1)
      mon_seen = mon_seen + 1;

  // short monitor reset pulse keeps the run brief: 4 cycles
  qa_watchdog_reset #(.RESET_PULSE_NS(200)) DUT
  (
    .REF_CLK_IN        (clk),
    .RESETN_IN         (rst_n),
    .ADDR_IN           (addr),
    .WDATA_IN          (wdata),
    .WR_IN             (wr),
    .RD_IN             (rd),
    .RDATA_OUT         (rdata),
    .QUESTION_IN       (question),
    .IN_WINDOW_IN      (in_win),
    .WINDOW_END_IN     (win_end),
    .BASE_TICK_IN      (tick),
    .EXT_RESET_N_IN    (ext_n),
    .ALARM_PIN_IN      (alarm_pin),
    .ALARM_PIN_OUT     (a_out),
    .ALARM_PIN_OE_OUT  (a_oe),
    .RESET_PIN_N_OUT   (rpin_n),
    .INTERNAL_ALARM_OUT(ialarm),
    .SHUTDOWN_OUT      (shut),
    .MON_RESET_OUT     (mon),
    .PARTIAL_RESET_OUT (partial)
  );
  mcu_responder partner
  (
    .question_in(question),
    .count_in   (cnt),
    .spoil_in   (spoil),
    .byte_out   (answer_byte)
  );

  function [2:0] next_err(input [2:0] e, input bad);
    next_err = bad ? (e == 3'h7 ? 3'h6 : e + 3'h1)
                   : (e == 3'h0 ? 3'h0 : e - 3'h1);
  endfunction

  task give_verdict;
    begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task check(input string nm, input [7:0] exp, input [7:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task wr_reg(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  task rd_reg(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
    end
  endtask

  task status(input occ);
    begin
      rd_reg(8'h03);
      check("status", {err >= 3'h5, err, rt, occ}, d);
    end
  endtask

  // four response bytes, most significant first; bad spoils byte pos
  task answer(input bad, input [1:0] pos);
    integer c;
    begin
      for (c = 3; c >= 0; c = c - 1)
      begin
        cnt = c[1:0];
        spoil = bad && pos == c;
        #1;
        wr_reg(8'h00, answer_byte);
        if (c > 0)
        begin
          rd_reg(8'h04);
          check("compare", {bad && pos >= c, c[1:0] - 2'h1}, d[2:0]);
        end
      end
      repeat (4) @(posedge clk);
      err = next_err(err, bad);
      rd_reg(8'h04);
      check("compare idle", 8'h03, d[2:0]);
    end
  endtask

  // a run started by a delay write or by the window end counts as error
  task bump(input by_delay);
    begin
      if (by_delay)
        wr_reg(8'h01, 8'h3F);
      else
      begin
        @(posedge clk) win_end <= 1'b1;
        @(posedge clk) win_end <= 1'b0;
      end
      repeat (4) @(posedge clk);
      err = next_err(err, 1'b1);
      status(1'b0);
    end
  endtask

  task done(input string nm);
    $display("test %0s finished", nm);
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    errors = errors + 1;
    give_verdict;
  end

  initial
  begin
    i = $urandom(32'h194f);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    status(1'b0);
    check("pins", 8'h31, {ialarm, a_oe, shut, mon, partial, rpin_n});
    rd_reg(8'h01);
    check("delay", 8'h3F, d);
    rd_reg(8'h04);
    check("compare", 8'h03, d[3:0]);
    rd_reg(8'h10);
    check("unmapped", 8'h00, d);
    done("reset values");
    qr = $urandom;
    for (i = 0; i < 16; i = i + 1)
    begin
      @(posedge clk) question <= i[3:0] ^ qr;
      answer(1'b0, 2'h0);
      status(1'b0);
    end
    done("correct answers");
    wr_reg(8'h02, 8'h04);
    // the control bit lands at this edge; look once it has settled
    @(negedge clk);
    check("test mode", 8'h04, {a_oe, ialarm, a_out});
    wr_reg(8'h02, 8'h00);
    @(negedge clk);
    check("test off", 8'h00, a_oe);
    done("test mode");
    for (i = 0; i < 4; i = i + 1)
      answer(1'b1, i);
    bump(1'b1);
    bump(1'b0);
    answer(1'b1, $urandom);
    answer(1'b1, $urandom);
    repeat (20) @(posedge clk);
    check("no monitor reset", 8'h00, mon_seen);
    status(1'b0);
    done("overflow disabled");
    wr_reg(8'h02, 8'h01);
    for (i = 0; i < 8; i = i + 1)
    begin
      answer(1'b1, $urandom);
      answer(1'b1, $urandom);
      repeat (20) @(posedge clk);
      if (i < 7)
        rt = rt + 3'h1;
      check("monitor resets", i < 7 ? i + 1 : 7, mon_seen);
      status(i < 7);
      status(1'b0);
    end
    wr_reg(8'h03, 8'h00);
    status(1'b0);
    done("reset tally");
    answer(1'b0, 2'h0);
    wr_reg(8'h01, 8'h20);
    repeat (4) @(posedge clk);
    answer(1'b0, 2'h0);
    repeat (3)
    begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
    end
    wr_reg(8'h02, 8'h02);
    repeat (6) @(posedge clk);
    err = 3'h6;
    status(1'b0);
    rd_reg(8'h01);
    check("delay", 8'h3F, d);
    rd_reg(8'h05);
    check("timer", 8'h00, d[4:0]);
    answer(1'b0, 2'h0);
    @(posedge clk) ext_n <= 1'b0;
    repeat (5) @(posedge clk);
    check("partial", 8'h02, {partial, rpin_n});
    ext_n <= 1'b1;
    repeat (6) @(posedge clk);
    err = 3'h6;
    status(1'b0);
    done("partial reset");
    @(posedge clk) rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rt = 3'h0;
    status(1'b0);
    done("undervoltage reset");
    give_verdict;
  end
endmodule // tb_qa_watchdog_reset
